// ### rtl/pcms_pkg.sv
// package for the pulse current measurement sequencer
// assumes a 200 MHz system clock and 32-bit classic Wishbone registers
package pcms_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int FIXED_DELAY_US = 25;
  localparam int FIXED_DELAY_CYC = FIXED_DELAY_US * CLK_MHZ;
  localparam int DELAY_STEP_US = 10;
  localparam int DELAY_STEP_CYC = DELAY_STEP_US * CLK_MHZ;
  localparam int DELAY_MAX_MS = 100;
  localparam int DELAY_MAX_STEPS = DELAY_MAX_MS * 1000 / DELAY_STEP_US;
  localparam int WIN_STEP_US = 1;
  localparam int WIN_STEP_CYC = WIN_STEP_US * CLK_MHZ;
  localparam int AUTO_MIN_US = 80;
  localparam int AUTO_MAX_MS = 833;
  localparam int AUTO_MAX_US = AUTO_MAX_MS * 1000;
  localparam int AVG_MAX = 100;

  // ---------------------------------------------------------------
  // current scale: one code is 0.5 mA in either range
  // ---------------------------------------------------------------
  localparam logic [15:0] HI_RANGE_MAX = 16'h2710;
  localparam logic [15:0] LO_RANGE_MAX = 16'h03E8;
  localparam logic [15:0] HI_STEP = 16'h000A;
  localparam logic [15:0] LO_STEP = 16'h0001;
  localparam logic [15:0] HI_HYST = 16'h0014;
  localparam logic [15:0] LO_HYST = 16'h0002;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LEVEL_HI = 8'h08;
  localparam logic [7:0] ADDR_LEVEL_LO = 8'h0C;
  localparam logic [7:0] ADDR_DELAY = 8'h10;
  localparam logic [7:0] ADDR_PEAK_WIN = 8'h14;
  localparam logic [7:0] ADDR_IDLE_WIN = 8'h18;
  localparam logic [7:0] ADDR_MEAN_WIN = 8'h1C;
  localparam logic [7:0] ADDR_AVG_CNT = 8'h20;
  localparam logic [7:0] ADDR_READING = 8'h24;

  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_DUAL = 4;
  localparam int CTRL_LOW_RANGE = 5;
  localparam int STAT_VALID = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_AUTO_BUSY = 2;
  localparam int STAT_RANGE = 3;

  localparam logic [19:0] WIN_RESET = 20'h00021;
  localparam logic [6:0] AVG_RESET = 7'h01;

  typedef enum logic [1:0] {
    PCMS_MODE_PEAK = 2'b00,
    PCMS_MODE_IDLE = 2'b01,
    PCMS_MODE_MEAN = 2'b10
  } pcms_mode_t;

  typedef enum logic [2:0] {
    PCMS_IDLE = 3'b000,
    PCMS_WAIT_EDGE = 3'b001,
    PCMS_DELAY = 3'b010,
    PCMS_INTEG = 3'b011,
    PCMS_AUTO_RISE = 3'b100,
    PCMS_AUTO_HIGH = 3'b101,
    PCMS_AUTO_LOW = 3'b110
  } pcms_state_t;

endpackage

// ### rtl/pcms_sequencer.sv
// pulse current measurement sequencer: edge detect, delays,
// integration windows, averaging and automatic window timing
// assumes current samples arrive on clk from the converter
`timescale 1ns/100ps
module pcms_sequencer
  import pcms_pkg::*;
#(
  parameter int FIXED_CYC = FIXED_DELAY_CYC,
  parameter int STEP_CYC = DELAY_STEP_CYC,
  parameter int WIN_CYC = WIN_STEP_CYC
) (
  input wire logic clk, // 200 MHz system clock
  input wire logic arst_n, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic wb_err_o, // wishbone error, unmapped address
  input wire logic sample_valid, // new current sample this cycle
  input wire logic signed [15:0] sample_i, // current, 0.5 mA per code
  input wire logic auto_range_req, // front end asks for autorange
  output logic range_low, // 1 selects the 500mA range
  output logic integ_on, // converter integrating
  output logic reading_valid // reading available
);

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic enable;
    logic dual;
    logic sel_low;
    logic range_low;
    logic [1:0] mode;
    logic [15:0] level_hi;
    logic [15:0] level_lo;
    logic [13:0] delay_steps;
    logic [19:0] peak_win;
    logic [19:0] idle_win;
    logic [19:0] mean_win;
    logic [6:0] avg_cnt;
    logic auto_req;
    logic armed;
    logic above;
    pcms_state_t state;
    logic [31:0] cnt;
    logic [19:0] unit;
    logic [19:0] win_left;
    logic [19:0] width_hi;
    logic [47:0] acc;
    logic [47:0] sum;
    logic [6:0] done;
    logic [31:0] reading;
    logic valid;
    logic auto_bad;
  } pcms_regs_t;

  pcms_regs_t r;
  pcms_regs_t next_r;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] snap_level(input logic [31:0] v,
                                             input logic [15:0] step,
                                             input logic [15:0] lim);
    logic [15:0] t;
    t = (v[31:16] != 16'h0000 || v[15:0] > lim) ? lim : v[15:0];
    snap_level = t - (t % step);
  endfunction

  function automatic logic [31:0] delay_cycles(input logic [13:0] s);
    delay_cycles = 32'(FIXED_CYC) + 32'(s) * 32'(STEP_CYC);
  endfunction

  logic wb_req;
  logic hit;
  logic [15:0] level;
  logic [15:0] hyst;
  logic rise;
  logic fall;
  logic signed [16:0] s17;
  logic [31:0] ctrl_view;
  logic [31:0] stat_view;

  assign wb_req = wb_cyc_i & wb_stb_i & ~r.ack & ~r.err;
  assign level = r.range_low ? r.level_lo : r.level_hi;
  assign hyst = r.range_low ? LO_HYST : HI_HYST;
  assign s17 = {sample_i[15], sample_i};
  // arm a hysteresis band above level, rearm only after dropping a hysteresis band below
  assign rise = sample_valid & ~r.above &
                (s17 >= $signed({1'b0, level}) + $signed({1'b0, hyst})) &
                (level != 16'h0000 || s17 > 17'sh00000);
  assign fall = sample_valid & r.above &
                (s17 + $signed({1'b0, hyst}) < $signed({1'b0, level}));
  assign ctrl_view = {26'h0, r.range_low, r.dual, 1'b0, r.mode, r.enable};
  assign stat_view = {28'h0, r.range_low, r.auto_req, r.state != PCMS_IDLE,
                      r.valid};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.err = 1'b0;
    hit = 1'b1;

    if (sample_valid) begin
      if (rise)
        next_r.above = 1'b1;
      else if (fall)
        next_r.above = 1'b0;
    end

    // range is latched when pulse mode is enabled
    if (!r.enable) begin
      next_r.range_low = r.dual & r.sel_low;
    end
    // auto_range_req deliberately unused in range choice

    // -------- sequencer --------
    case (r.state)
      PCMS_IDLE: begin
        if (r.enable && r.auto_req) begin
          next_r.state = PCMS_AUTO_RISE;
        end else if (r.enable) begin
          next_r.state = PCMS_WAIT_EDGE;
          next_r.acc = 48'h0;
          next_r.done = 7'h00;
        end
      end
      PCMS_WAIT_EDGE: begin
        // a pending auto timing request preempts edge waiting
        if (!r.enable || r.auto_req) begin
          next_r.state = PCMS_IDLE;
        end else if ((r.mode == PCMS_MODE_IDLE) ? fall : rise) begin
          next_r.state = PCMS_DELAY;
          next_r.cnt = delay_cycles(r.delay_steps);
        end
      end
      PCMS_DELAY: begin
        if (r.cnt > 32'h1) begin
          next_r.cnt = r.cnt - 32'h1;
        end else begin
          next_r.state = PCMS_INTEG;
          next_r.unit = 20'h0;
          next_r.sum = 48'h0;
          case (r.mode)
            PCMS_MODE_PEAK: next_r.win_left = r.peak_win;
            PCMS_MODE_IDLE: next_r.win_left = r.idle_win;
            default: next_r.win_left = r.mean_win;
          endcase
        end
      end
      PCMS_INTEG: begin
        if (sample_valid)
          next_r.sum = r.sum + 48'(signed'(sample_i));
        if (r.unit == 20'(WIN_CYC - 1)) begin
          next_r.unit = 20'h0;
          next_r.win_left = r.win_left - 20'h1;
        end else begin
          next_r.unit = r.unit + 20'h1;
        end
        if (r.unit == 20'(WIN_CYC - 1) && r.win_left <= 20'h1) begin
          // one window sum is folded into the reading accumulator
          next_r.acc = r.acc + 48'(next_r.sum);
          next_r.done = r.done + 7'h01;
          if (r.done + 7'h01 >= r.avg_cnt) begin
            next_r.reading = 32'(next_r.acc / 48'(r.avg_cnt));
            next_r.valid = 1'b1;
            next_r.acc = 48'h0;
            next_r.done = 7'h00;
          end
          next_r.state = r.enable ? PCMS_WAIT_EDGE : PCMS_IDLE;
        end
      end
      PCMS_AUTO_RISE: begin
        if (rise) begin
          next_r.state = PCMS_AUTO_HIGH;
          next_r.cnt = 32'h0;
          // the edge sample itself is the first counted cycle
          next_r.unit = 20'(1 % WIN_CYC);
        end
      end
      PCMS_AUTO_HIGH, PCMS_AUTO_LOW: begin
        if (r.unit == 20'(WIN_CYC - 1)) begin
          next_r.unit = 20'h0;
          next_r.cnt = r.cnt + 32'h1;
        end else begin
          next_r.unit = r.unit + 20'h1;
        end
        if (r.cnt > 32'(AUTO_MAX_US)) begin
          next_r.auto_req = 1'b0;
          next_r.auto_bad = 1'b1;
          next_r.state = PCMS_IDLE;
        end else if (r.state == PCMS_AUTO_HIGH && fall) begin
          next_r.width_hi = r.cnt[19:0];
          next_r.cnt = 32'h0;
          next_r.unit = 20'(1 % WIN_CYC);
          next_r.state = PCMS_AUTO_LOW;
        end else if (r.state == PCMS_AUTO_LOW && rise) begin
          if (r.width_hi >= 20'(AUTO_MIN_US) &&
              r.cnt >= 32'(AUTO_MIN_US)) begin
            next_r.peak_win = r.width_hi;
            next_r.idle_win = r.cnt[19:0];
            next_r.mean_win = r.width_hi + r.cnt[19:0];
            next_r.auto_bad = 1'b0;
          end else begin
            next_r.auto_bad = 1'b1;
          end
          next_r.auto_req = 1'b0;
          next_r.state = PCMS_IDLE;
        end
      end
      default: next_r.state = PCMS_IDLE;
    endcase

    // -------- wishbone slave, one wait state --------
    if (wb_req) begin
      next_r.rdata = 32'h0;
      if (wb_adr_i == ADDR_CTRL) begin
        next_r.rdata = ctrl_view;
        if (wb_we_i && wb_sel_i[0]) begin
          next_r.enable = wb_dat_i[CTRL_ENABLE];
          next_r.mode = wb_dat_i[CTRL_MODE_LSB +: 2] == 2'b11 ?
                        PCMS_MODE_PEAK : wb_dat_i[CTRL_MODE_LSB +: 2];
          next_r.dual = wb_dat_i[CTRL_DUAL];
          next_r.sel_low = wb_dat_i[CTRL_LOW_RANGE];
          if (wb_dat_i[CTRL_AUTO])
            next_r.auto_req = 1'b1;
          if (!wb_dat_i[CTRL_ENABLE])
            next_r.state = PCMS_IDLE;
        end
      end else if (wb_adr_i == ADDR_STATUS) begin
        next_r.rdata = stat_view | {27'h0, r.auto_bad, 4'h0};
        // valid is read-clear, a reading landing now still wins
        if (!wb_we_i && !(next_r.done == 7'h00 && r.state == PCMS_INTEG
            && next_r.state != PCMS_INTEG))
          next_r.valid = 1'b0;
      end else if (wb_adr_i == ADDR_LEVEL_HI) begin
        next_r.rdata = {16'h0, r.level_hi};
        if (wb_we_i)
          next_r.level_hi = snap_level(wb_dat_i, HI_STEP, HI_RANGE_MAX);
      end else if (wb_adr_i == ADDR_LEVEL_LO) begin
        next_r.rdata = {16'h0, r.level_lo};
        if (wb_we_i)
          next_r.level_lo = snap_level(wb_dat_i, LO_STEP, LO_RANGE_MAX);
      end else if (wb_adr_i == ADDR_DELAY) begin
        next_r.rdata = {18'h0, r.delay_steps};
        if (wb_we_i)
          next_r.delay_steps = wb_dat_i > 32'(DELAY_MAX_STEPS) ?
                               14'(DELAY_MAX_STEPS) : wb_dat_i[13:0];
      end else if (wb_adr_i == ADDR_PEAK_WIN) begin
        next_r.rdata = {12'h0, r.peak_win};
        if (wb_we_i && wb_dat_i[19:0] != 20'h0)
          next_r.peak_win = wb_dat_i[19:0];
      end else if (wb_adr_i == ADDR_IDLE_WIN) begin
        next_r.rdata = {12'h0, r.idle_win};
        if (wb_we_i && wb_dat_i[19:0] != 20'h0)
          next_r.idle_win = wb_dat_i[19:0];
      end else if (wb_adr_i == ADDR_MEAN_WIN) begin
        next_r.rdata = {12'h0, r.mean_win};
        if (wb_we_i && wb_dat_i[19:0] != 20'h0)
          next_r.mean_win = wb_dat_i[19:0];
      end else if (wb_adr_i == ADDR_AVG_CNT) begin
        next_r.rdata = {25'h0, r.avg_cnt};
        if (wb_we_i)
          next_r.avg_cnt = (wb_dat_i == 32'h0) ? 7'h01 :
                           (wb_dat_i > 32'(AVG_MAX)) ? 7'(AVG_MAX) :
                           wb_dat_i[6:0];
      end else if (wb_adr_i == ADDR_READING) begin
        next_r.rdata = r.reading;
      end else begin
        hit = 1'b0;
      end
      next_r.ack = hit;
      next_r.err = ~hit;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.state <= PCMS_IDLE;
      r.peak_win <= WIN_RESET;
      r.idle_win <= WIN_RESET;
      r.mean_win <= WIN_RESET;
      r.avg_cnt <= AVG_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.rdata;
  assign wb_ack_o = r.ack;
  assign wb_err_o = r.err;
  assign range_low = r.range_low;
  assign integ_on = r.state == PCMS_INTEG;
  assign reading_valid = r.valid;

endmodule

// ### tb/pcms_front_end.sv
// pulsed load model: one current sample every clock
// assumes the bench sets both levels and widths in cycles
`timescale 1ns/100ps
module pcms_front_end (
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire logic run, // pulse train on
  input wire logic signed [15:0] hi_code, // pulse level
  input wire logic signed [15:0] lo_code, // idle level
  input wire logic [15:0] hi_cyc, // high width
  input wire logic [15:0] lo_cyc, // low width
  output logic sample_valid, // sample strobe
  output logic signed [15:0] sample_i // current
);
  logic [15:0] cnt;
  logic hi;
  assign sample_valid = arst_n;
  assign sample_i = hi ? hi_code : lo_code;
  // train always restarts low, so the first edge is a rise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 16'h0000;
      hi <= 1'b0;
    end else if (!run) begin
      cnt <= 16'h0000;
      hi <= 1'b0;
    end else if (cnt >= (hi ? hi_cyc : lo_cyc) - 16'h0001) begin
      cnt <= 16'h0000;
      hi <= !hi;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// ### tb/pcms_sequencer_assertions.sv
// port checker for the sequencer
// assumes it is bound into pcms_sequencer, one clock
`timescale 1ns/100ps
module pcms_checker
  import pcms_pkg::*;
#(parameter int WIN_CYC = 2) (
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic wb_ack_o, // ack
  input wire logic wb_err_o, // error
  input wire logic range_low, // low range
  input wire logic integ_on, // window
  input wire logic reading_valid // reading
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic [19:0] run;
  logic [19:0] next_run;
  logic req;
  logic rd_stat;
  assign req = wb_cyc_i && wb_stb_i;
  assign rd_stat = req && !wb_we_i && wb_adr_i == ADDR_STATUS;
  always_comb next_run = integ_on ? run + 20'h00001 : 20'h00000;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) run <= 20'h00000;
    else run <= next_run;
  end
  sequence s_take;
    req && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_reply;
    wb_ack_o || wb_err_o;
  endsequence
  property p_answer;
    s_take |=> s_reply;
  endproperty
  a_answer: assert property (p_answer) else $error("no reply");
  property p_pulse;
    s_reply |=> !wb_ack_o && !wb_err_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reply too long");
  property p_err;
    wb_err_o |-> !wb_ack_o && wb_adr_i > ADDR_READING;
  endproperty
  a_err: assert property (p_err) else $error("bad error reply");
  property p_ack;
    wb_ack_o |-> wb_adr_i <= ADDR_READING;
  endproperty
  a_ack: assert property (p_ack) else $error("ack on unmapped");
  property p_range;
    $changed(range_low) |-> $past(req && wb_we_i && wb_adr_i == ADDR_CTRL)
      || $past(req && wb_we_i && wb_adr_i == ADDR_CTRL, 2);
  endproperty
  a_range: assert property (p_range) else $error("range moved");
  property p_win;
    $fell(integ_on) |-> run >= WIN_CYC;
  endproperty
  a_win: assert property (p_win) else $error("window too short");
  property p_valid;
    $rose(reading_valid) |-> $past(integ_on) || $past(integ_on, 2)
      || $past(integ_on, 3);
  endproperty
  a_valid: assert property (p_valid) else $error("early reading");
  property p_clear;
    $fell(reading_valid) |-> $past(rd_stat) || $past(rd_stat, 2);
  endproperty
  a_clear: assert property (p_clear) else $error("valid lost");
endmodule
bind pcms_sequencer pcms_checker #(.WIN_CYC(WIN_CYC)) u_checker (
  .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .range_low(range_low), .integ_on(integ_on),
  .reading_valid(reading_valid));

// ### tb/pulse_current_measure_sequencer_bench.sv
// self-checking bench for the pulse current sequencer
// assumes shortened timing parameters and the load model
`timescale 1ns/100ps
module pulse_current_measure_sequencer_bench;
  import pcms_pkg::*;
  localparam int FC = 5;
  localparam int SC = 2;
  localparam int WC = 2;
  localparam int DLY = FC + 3 * SC;
  localparam logic [32:0] ERR = 33'h100000000;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  localparam logic [7:0] RA [4] = '{ADDR_LEVEL_HI, ADDR_LEVEL_LO,
    ADDR_DELAY, ADDR_AVG_CNT};
  localparam logic [31:0] RV [4] = '{32'h2710, 32'h3E8, 32'h2710, 32'h64};
  logic clk, arst_n, cyc, stb, we, ack, err, sv, arr, rng, integ, rvalid;
  logic run;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic signed [15:0] si, hc, lc, prev, h, l;
  logic [15:0] hw, lw;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int mismatches, check_count, cycles, exp_len, since, len, rises, wins;
  always #2.5 clk = ~clk;
  pcms_sequencer #(.FIXED_CYC(FC), .STEP_CYC(SC), .WIN_CYC(WC)) dut (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .sample_valid(sv),
    .sample_i(si), .auto_range_req(arr), .range_low(rng),
    .integ_on(integ), .reading_valid(rvalid));
  pcms_front_end load (.clk(clk), .arst_n(arst_n), .run(run),
    .hi_code(hc), .lo_code(lc), .hi_cyc(hw), .lo_cyc(lw),
    .sample_valid(sv), .sample_i(si));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [32:0] e,
      input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e, input logic [32:0] m,
      output logic [31:0] r);
    int n;
    n = 0;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 100);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 33'h0, ERR, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, {1'b0, e}, ALL, q);
  endtask
  task automatic wait_auto();
    int n;
    n = 0;
    q = 32'h4;
    while (q[STAT_AUTO_BUSY] !== 1'b0 && n < 300) begin
      repeat (20) @(posedge clk);
      bus(1'b0, ADDR_STATUS, 32'h0, 33'h0, 33'h0, q);
      n++;
    end
  endtask
  task automatic meas(input logic [1:0] m, input int w,
      input logic [31:0] e);
    int n;
    n = 0;
    exp_len = w * WC;
    wins = 0;
    run <= 1'b1;
    wr(ADDR_CTRL, {28'h0, m, 2'b01});
    while (rvalid !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    check("windows", 33'h1, 33'(wins >= 2));
    rd(ADDR_READING, e);
    bus(1'b0, ADDR_STATUS, 32'h0, 33'h1, 33'h1, q);
    exp_len = 0;
    wr(ADDR_CTRL, 32'h0);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    check("cleared", 33'h0, {32'h0, rvalid});
  endtask
  // ---------------------------------------------------------------
  // watcher: bus replies, windows, delays, timeout
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
    arr <= 1'($urandom);
    prev <= si;
    since <= (si != prev) ? 0 : since + 1;
    len <= integ ? len + 1 : 0;
    if (integ === 1'b1 && len == 0) begin
      rises <= rises + 1;
      if (exp_len != 0)
        check("delay", 33'h1, 33'(since >= DLY && since <= DLY + 4));
    end
    if (integ === 1'b0 && len != 0) begin
      wins <= wins + 1;
      if (exp_len != 0)
        check("window", 33'(exp_len), 33'(len));
    end
    if (ack === 1'b1 || err === 1'b1) begin
      if (exp_q.size() == 0) check("reply", 33'h0, ALL);
      else check("reply", exp_q.pop_front(), {err, rdat} & msk_q.pop_front());
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    arr = 1'b0;
    run = 1'b0;
    prev = 16'sh0000;
    hw = 16'h003C;
    lw = 16'h003C;
    void'($urandom(32'h3B1E));
    h = 16'(100 + $urandom % 300);
    l = 16'($urandom % 20);
    hc = 16'h003C + HI_HYST - 16'h0001;
    lc = l;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd(ADDR_PEAK_WIN, 32'h21);
    rd(ADDR_IDLE_WIN, 32'h21);
    rd(ADDR_MEAN_WIN, 32'h21);
    rd(ADDR_AVG_CNT, 32'h1);
    bus(1'b0, 8'h30, 32'h0, ERR, ERR, q);
    for (int i = 0; i < 4; i++) begin
      wr(RA[i], RV[i]);
      rd(RA[i], RV[i]);
    end
    wr(ADDR_LEVEL_HI, 32'h3C);
    wr(ADDR_DELAY, 32'h3);
    wr(ADDR_AVG_CNT, 32'h2);
    wr(ADDR_PEAK_WIN, 32'hA);
    wr(ADDR_IDLE_WIN, 32'h8);
    wr(ADDR_MEAN_WIN, 32'hF);
    wr(ADDR_PEAK_WIN, 32'h0);
    rd(ADDR_PEAK_WIN, 32'hA);
    run <= 1'b1;
    wr(ADDR_CTRL, 32'h1);
    repeat (500) @(posedge clk);
    check("no trigger", 33'h0, 33'(rises));
    wr(ADDR_CTRL, 32'h0);
    run <= 1'b0;
    hc <= h;
    meas(2'b00, 10, 32'(h * 20));
    meas(2'b01, 8, 32'(l * 16));
    meas(2'b10, 15, 32'(h * 30));
    hw <= 16'h00C8;
    lw <= 16'h00F0;
    run <= 1'b1;
    wr(ADDR_CTRL, 32'h3);
    wait_auto();
    rd(ADDR_PEAK_WIN, 32'h64);
    rd(ADDR_IDLE_WIN, 32'h78);
    rd(ADDR_MEAN_WIN, 32'hDC);
    hw <= 16'h003C;
    lw <= 16'h003C;
    wr(ADDR_CTRL, 32'h3);
    wait_auto();
    bus(1'b0, ADDR_STATUS, 32'h0, 33'h10, 33'h10, q);
    rd(ADDR_MEAN_WIN, 32'hDC);
    run <= 1'b0;
    wr(ADDR_CTRL, 32'h30);
    repeat (2) @(posedge clk);
    check("range", 33'h1, {32'h0, rng});
    wr(ADDR_CTRL, 32'h31);
    wr(ADDR_CTRL, 32'h11);
    repeat (2) @(posedge clk);
    check("range", 33'h1, {32'h0, rng});
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_CTRL, 32'h20);
    repeat (2) @(posedge clk);
    check("range", 33'h0, {32'h0, rng});
    complete_run();
  end
endmodule
